// [rtl/dual_timer_count_control.sv]
// Control, count registers and interrupt logic for two timers
// Operation
// [R1] Timer B overflow sets control bit 7
// [R2] Timer B flag cleared on service entry
// [R3] Timer A overflow sets control bit 5
// [R4] Timer A flag cleared on service entry
// [R5] Timer B run bit 6 holds count
// [R6] Timer A run bit 4 holds count
// [R7] Timer A bytes at 8AH, 8CH
// [R8] Timer B bytes at 8BH, 8DH
// [R9] Reset clears control and count bytes
// [R10] Count only when run and gate allow
// [R11] 13-bit mode rolls 1FFFh to zero
// [R12] 16-bit mode rolls FFFFH to zero
// [R13] Auto-reload low byte from high byte
// [R14] Count byte writes take effect immediately
`timescale 1ns/1ps
module dual_timer_count_control
  import timer_pair_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] address,
  input wire logic [timer_pair_pkg::DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [timer_pair_pkg::DATA_W-1:0] read_data,
  input wire logic timer_a_service_entry,
  input wire logic timer_b_service_entry,
  input wire logic external_interrupt_pin_a,
  input wire logic external_interrupt_pin_b,
  output logic interrupt
);
  // Register state
  logic [7:0] control_q, control_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] prescale_q, prescale_d;
  logic [1:0] irq_status_q, irq_status_d;
  logic [1:0] irq_mask_q, irq_mask_d;
  logic [7:0] read_data_q, read_data_d;
  logic [3:0] div_a_q, div_a_d, div_b_q, div_b_d;
  logic tick_a, tick_b;
  logic ovf_a, ovf_b;
  logic [7:0] a_low, a_high, b_low, b_high;
  timer_mode_t mode_a, mode_b;

  function automatic logic hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction

  function automatic logic [3:0] div_limit(input logic fast);
    div_limit = fast ? DIV_FAST : DIV_SLOW;
  endfunction

  assign mode_a = timer_mode_t'(mode_q[MODE_A_LSB+MODE_SEL_LSB +: 2]);
  assign mode_b = timer_mode_t'(mode_q[MODE_B_LSB+MODE_SEL_LSB +: 2]);

  // Peripheral clock dividers
  always_comb begin
    tick_a = (div_a_q >= div_limit(prescale_q[BIT_A_FAST]));
    tick_b = (div_b_q >= div_limit(prescale_q[BIT_B_FAST]));
    div_a_d = tick_a ? 4'h0 : div_a_q + 4'h1;
    div_b_d = tick_b ? 4'h0 : div_b_q + 4'h1;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      div_a_q <= 4'h0;
      div_b_q <= 4'h0;
    end else begin
      div_a_q <= div_a_d;
      div_b_q <= div_b_d;
    end
  end

  timer_count_unit timer_a (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_a),
    .run(control_q[BIT_A_RUN]), // [R6]
    .gate(mode_q[MODE_A_LSB+MODE_GATE]),
    .external_interrupt_pin(external_interrupt_pin_a),
    .mode(mode_a),
    .write_low(hit(write_strobe, address, OFS_A_LOW)), // [R7]
    .write_high(hit(write_strobe, address, OFS_A_HIGH)), // [R7]
    .wdata(write_data),
    .count_low(a_low),
    .count_high(a_high),
    .overflow(ovf_a)
  );

  timer_count_unit timer_b (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_b),
    .run(control_q[BIT_B_RUN]), // [R5]
    .gate(mode_q[MODE_B_LSB+MODE_GATE]),
    .external_interrupt_pin(external_interrupt_pin_b),
    .mode(mode_b),
    .write_low(hit(write_strobe, address, OFS_B_LOW)), // [R8]
    .write_high(hit(write_strobe, address, OFS_B_HIGH)), // [R8]
    .wdata(write_data),
    .count_low(b_low),
    .count_high(b_high),
    .overflow(ovf_b)
  );

  // Control, mode and interrupt registers
  always_comb begin
    control_d = control_q;
    mode_d = mode_q;
    prescale_d = prescale_q;
    irq_mask_d = irq_mask_q;
    irq_status_d = irq_status_q;
    if (hit(write_strobe, address, OFS_CONTROL)) begin
      control_d = write_data;
    end
    if (hit(write_strobe, address, OFS_MODE)) begin
      mode_d = write_data;
    end
    if (hit(write_strobe, address, OFS_PRESCALE)) begin
      prescale_d = write_data & 8'h18;
    end
    if (hit(write_strobe, address, OFS_IRQ_MASK)) begin
      irq_mask_d = write_data[1:0];
    end
    if (hit(write_strobe, address, OFS_IRQ_STATUS)) begin
      irq_status_d = irq_status_q & ~write_data[1:0];
    end
    if (timer_a_service_entry) begin
      control_d[BIT_A_FLAG] = 1'b0; // [R4]
    end
    if (timer_b_service_entry) begin
      control_d[BIT_B_FLAG] = 1'b0; // [R2]
    end
    if (ovf_a) begin
      control_d[BIT_A_FLAG] = 1'b1; // [R3]
      irq_status_d[IRQ_A] = 1'b1;
    end
    if (ovf_b) begin
      control_d[BIT_B_FLAG] = 1'b1; // [R1]
      irq_status_d[IRQ_B] = 1'b1;
    end
  end

  // Read mux
  always_comb begin
    read_data_d = 8'h00;
    if (read_strobe) begin
      case (address)
        OFS_CONTROL: read_data_d = control_q;
        OFS_MODE: read_data_d = mode_q;
        OFS_A_LOW: read_data_d = a_low; // [R7]
        OFS_A_HIGH: read_data_d = a_high; // [R7]
        OFS_B_LOW: read_data_d = b_low; // [R8]
        OFS_B_HIGH: read_data_d = b_high; // [R8]
        OFS_PRESCALE: read_data_d = prescale_q;
        OFS_IRQ_STATUS: read_data_d = {6'h00, irq_status_q};
        OFS_IRQ_MASK: read_data_d = {6'h00, irq_mask_q};
        default: read_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      control_q <= RESET_BYTE; // [R9]
      mode_q <= RESET_BYTE;
      prescale_q <= RESET_BYTE;
      irq_status_q <= 2'h0;
      irq_mask_q <= 2'h0;
      read_data_q <= 8'h00;
    end else begin
      control_q <= control_d;
      mode_q <= mode_d;
      prescale_q <= prescale_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      read_data_q <= read_data_d;
    end
  end

  assign read_data = read_data_q;
  assign interrupt = |(irq_status_q & irq_mask_q);
endmodule // dual_timer_count_control

// [rtl/timer_pair_pkg.sv]
// Package of offsets, fields, resets and modes for the dual timer block
package timer_pair_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h88;
  localparam logic [7:0] OFS_MODE = 8'h89;
  localparam logic [7:0] OFS_A_LOW = 8'h8A;
  localparam logic [7:0] OFS_B_LOW = 8'h8B;
  localparam logic [7:0] OFS_A_HIGH = 8'h8C;
  localparam logic [7:0] OFS_B_HIGH = 8'h8D;
  localparam logic [7:0] OFS_PRESCALE = 8'h8E;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF1;
  localparam int BIT_B_FLAG = 7;
  localparam int BIT_B_RUN = 6;
  localparam int BIT_A_FLAG = 5;
  localparam int BIT_A_RUN = 4;
  localparam int BIT_B_FAST = 4;
  localparam int BIT_A_FAST = 3;
  localparam int MODE_B_LSB = 4;
  localparam int MODE_A_LSB = 0;
  localparam int MODE_GATE = 3;
  localparam int MODE_SEL_LSB = 0;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] DIV_SLOW = 4'hB;
  localparam logic [3:0] DIV_FAST = 4'h3;
  localparam logic [12:0] MAX13 = 13'h1FFF;
  localparam logic [7:0] MAX8 = 8'hFF;
  localparam logic [4:0] MAX5 = 5'h1F;
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_HALT} timer_mode_t;
endpackage

// [rtl/timer_count_unit.sv]
// One timer counter with its count bytes, modes and overflow event
`timescale 1ns/1ps
module timer_count_unit
  import timer_pair_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic run,
  input wire logic gate,
  input wire logic external_interrupt_pin,
  input wire timer_pair_pkg::timer_mode_t mode,
  input wire logic write_low,
  input wire logic write_high,
  input wire logic [7:0] wdata,
  output logic [7:0] count_low,
  output logic [7:0] count_high,
  output logic overflow
);
  logic [7:0] low_q, low_d, high_q, high_d;
  logic ovf_d;
  logic step;

  assign step = tick && run && (!gate || external_interrupt_pin); // [R10] [R5] [R6]

  always_comb begin
    low_d = low_q;
    high_d = high_q;
    ovf_d = 1'b0;
    if (step) begin
      case (mode)
        MODE_13BIT: begin
          if ({high_q, low_q[4:0]} == MAX13) begin
            high_d = 8'h00; // [R11]
            low_d = {low_q[7:5], 5'h00};
            ovf_d = 1'b1;
          end else if (low_q[4:0] == MAX5) begin
            low_d = {low_q[7:5], 5'h00};
            high_d = high_q + 8'h01;
          end else begin
            low_d = {low_q[7:5], low_q[4:0] + 5'h01};
          end
        end
        MODE_16BIT: begin
          {high_d, low_d} = {high_q, low_q} + 16'h0001; // [R12]
          ovf_d = ({high_q, low_q} == 16'hFFFF);
        end
        MODE_RELOAD: begin
          if (low_q == MAX8) begin
            low_d = high_q; // [R13]
            ovf_d = 1'b1;
          end else begin
            low_d = low_q + 8'h01;
          end
        end
        default: begin
          low_d = low_q;
        end
      endcase
    end
    if (write_low) begin
      low_d = wdata; // [R14]
    end
    if (write_high) begin
      high_d = wdata; // [R14]
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      low_q <= RESET_BYTE; // [R9]
      high_q <= RESET_BYTE;
    end else begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  assign count_low = low_q;
  assign count_high = high_q;
  assign overflow = ovf_d;
endmodule // timer_count_unit

// [testbench/dual_timer_count_control_properties.sv]
// Port assertions for the dual timer block
`timescale 1ns/1ps
module dual_timer_count_control_properties
  import timer_pair_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] address,
  input wire logic [timer_pair_pkg::DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [timer_pair_pkg::DATA_W-1:0] read_data,
  input wire logic timer_a_service_entry,
  input wire logic timer_b_service_entry,
  input wire logic external_interrupt_pin_a,
  input wire logic external_interrupt_pin_b,
  input wire logic interrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic wr_ctl = write_strobe && address == OFS_CONTROL;
  wire logic rd_ctl = read_strobe && address == OFS_CONTROL;
  wire logic wr_mask = write_strobe && address == OFS_IRQ_MASK;
  property p_idle; !read_strobe |=> read_data == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_run; wr_ctl ##1 rd_ctl |=> (read_data & 8'h50) == ($past(write_data, 2) & 8'h50);
  endproperty
  a_run: assert property (p_run) else $error("run bits");
  property p_mode; write_strobe && address == OFS_MODE ##1 read_strobe && address == OFS_MODE
    |=> read_data == $past(write_data, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_b_clr; timer_b_service_entry && !wr_ctl ##1 rd_ctl |=> !read_data[BIT_B_FLAG];
  endproperty
  a_b_clr: assert property (p_b_clr) else $error("b clear");
  property p_a_clr; timer_a_service_entry && !wr_ctl ##1 rd_ctl |=> !read_data[BIT_A_FLAG];
  endproperty
  a_a_clr: assert property (p_a_clr) else $error("a clear");
  property p_b_set; wr_ctl && write_data[BIT_B_FLAG] && !timer_b_service_entry ##1 rd_ctl
    |=> read_data[BIT_B_FLAG]; endproperty
  a_b_set: assert property (p_b_set) else $error("b set");
  property p_a_set; wr_ctl && write_data[BIT_A_FLAG] && !timer_a_service_entry ##1 rd_ctl
    |=> read_data[BIT_A_FLAG]; endproperty
  a_a_set: assert property (p_a_set) else $error("a set");
  property p_irq; wr_mask && write_data == 8'h00 ##1 !wr_mask |=> !interrupt; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  c_a_flag: cover property (rd_ctl ##1 read_data[BIT_A_FLAG]);
  c_b_flag: cover property (rd_ctl ##1 read_data[BIT_B_FLAG]);
  c_irq: cover property (interrupt);
endmodule // dual_timer_count_control_properties

bind dual_timer_count_control dual_timer_count_control_properties i_props (
  .clock(clock),
  .resetn(resetn),
  .address(address),
  .write_data(write_data),
  .write_strobe(write_strobe),
  .read_strobe(read_strobe),
  .read_data(read_data),
  .timer_a_service_entry(timer_a_service_entry),
  .timer_b_service_entry(timer_b_service_entry),
  .external_interrupt_pin_a(external_interrupt_pin_a),
  .external_interrupt_pin_b(external_interrupt_pin_b),
  .interrupt(interrupt)
);

// [testbench/dual_timer_count_control_bench.sv]
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
module dual_timer_count_control_bench;
  import timer_pair_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0, interrupt;
  logic timer_a_service_entry = 1'b0, timer_b_service_entry = 1'b0;
  logic external_interrupt_pin_a = 1'b1, external_interrupt_pin_b = 1'b1;
  logic [7:0] address = 8'h00, write_data = 8'h00, read_data, v;
  int n_fail = 0;
  int n_checks = 0;
  dual_timer_count_control i_dut (
    .clock(clock),
    .resetn(resetn),
    .address(address),
    .write_data(write_data),
    .write_strobe(write_strobe),
    .read_strobe(read_strobe),
    .read_data(read_data),
    .timer_a_service_entry(timer_a_service_entry),
    .timer_b_service_entry(timer_b_service_entry),
    .external_interrupt_pin_a(external_interrupt_pin_a),
    .external_interrupt_pin_b(external_interrupt_pin_b),
    .interrupt(interrupt)
  );
  initial begin
    forever #2.5 clock = ~clock;
  end
  task check(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("Checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    read_strobe <= 1'b0;
    @(posedge clock);
  endtask
  task rd(logic [7:0] a);
    address <= a;
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(posedge clock);
    v = read_data;
  endtask
  task rc(logic [7:0] a, logic [7:0] e);
    rd(a);
    check(v, e);
  endtask
  task idle(int n);
    write_strobe <= 1'b0;
    read_strobe <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task t_regs;
    logic [7:0] regs[5] = '{OFS_CONTROL, OFS_A_LOW, OFS_B_LOW, OFS_A_HIGH, OFS_B_HIGH};
    foreach (regs[i]) rc(regs[i], RESET_BYTE);
    rc(8'h80, 8'h00);
    for (int i = 1; i < 5; i++) begin
      wr(regs[i], 8'h50 + 8'(i));
      rc(regs[i], 8'h50 + 8'(i));
    end
  endtask
  task t_wrap(logic [7:0] mode, lo_a, lo, hi, eh, el, int rb);
    wr(OFS_MODE, mode);
    rc(OFS_MODE, mode);
    wr(lo_a, lo);
    wr(lo_a + 8'h02, hi);
    wr(OFS_CONTROL, 8'h01 << rb);
    v = 8'h00;
    for (int i = 0; i < 40 && v[rb + 1] !== 1'b1; i++) rd(OFS_CONTROL);
    if (v[rb + 1] !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: no overflow flag", $time);
      end_sim();
    end
    wr(OFS_CONTROL, 8'h02 << rb);
    rc(OFS_CONTROL, 8'h02 << rb);
    rc(lo_a, el);
    idle(30);
    rc(lo_a, el);
    rc(lo_a + 8'h02, eh);
    timer_a_service_entry <= rb == 4;
    timer_b_service_entry <= rb == 6;
    @(posedge clock);
    timer_a_service_entry <= 1'b0;
    timer_b_service_entry <= 1'b0;
    rc(OFS_CONTROL, 8'h00);
  endtask
  task t_rate;
    wr(OFS_PRESCALE, 8'h08);
    rc(OFS_PRESCALE, 8'h08);
    wr(OFS_MODE, 8'h01);
    wr(OFS_A_LOW, 8'h00);
    wr(OFS_A_HIGH, 8'h00);
    wr(OFS_CONTROL, 8'h10);
    idle(47);
    wr(OFS_CONTROL, 8'h00);
    rc(OFS_A_LOW, 8'h0C);
    wr(OFS_PRESCALE, 8'h00);
    wr(OFS_A_LOW, 8'h00);
    wr(OFS_CONTROL, 8'h10);
    idle(47);
    wr(OFS_CONTROL, 8'h00);
    rc(OFS_A_LOW, 8'h04);
    wr(OFS_MODE, 8'h03);
    wr(OFS_CONTROL, 8'h10);
    idle(30);
    wr(OFS_CONTROL, 8'h00);
    rc(OFS_A_LOW, 8'h04);
  endtask
  task t_gate;
    external_interrupt_pin_a <= 1'b0;
    external_interrupt_pin_b <= 1'b0;
    wr(OFS_MODE, 8'h99);
    wr(OFS_A_LOW, 8'h33);
    wr(OFS_B_LOW, 8'h44);
    wr(OFS_CONTROL, 8'h50);
    idle(40);
    rc(OFS_A_LOW, 8'h33);
    rc(OFS_B_LOW, 8'h44);
    external_interrupt_pin_a <= 1'b1;
    idle(40);
    rd(OFS_A_LOW);
    check({7'h00, v !== 8'h33}, 8'h01);
    rc(OFS_B_LOW, 8'h44);
    wr(OFS_CONTROL, 8'h00);
    external_interrupt_pin_b <= 1'b1;
  endtask
  task t_irq;
    rc(OFS_IRQ_STATUS, 8'h03);
    wr(OFS_IRQ_MASK, 8'h02);
    idle(2);
    check({7'h00, interrupt}, 8'h01);
    wr(OFS_IRQ_MASK, 8'h00);
    idle(2);
    check({7'h00, interrupt}, 8'h00);
    wr(OFS_IRQ_STATUS, 8'h01);
    rc(OFS_IRQ_STATUS, 8'h02);
    wr(OFS_IRQ_MASK, 8'h01);
    idle(2);
    check({7'h00, interrupt}, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_wrap(8'h01, OFS_A_LOW, 8'hFF, 8'hFF, 8'h00, 8'h00, 4);
    t_wrap(8'h00, OFS_B_LOW, 8'h1F, 8'hFF, 8'h00, 8'h00, 6);
    t_wrap(8'h02, OFS_A_LOW, 8'hFF, 8'h7A, 8'h7A, 8'h7A, 4);
    t_rate();
    t_gate();
    t_irq();
    end_sim();
  end
endmodule // dual_timer_count_control_bench
